//--- hw/osr_pkg.sv
// Package: sizes, opcodes, timing, states and carriers of the security register
package osr_pkg;

   //----------------------------------------------------------------------
   // Register layout
   //----------------------------------------------------------------------
   localparam int          REG_BYTES   = 128;
   localparam int          USER_BYTES  = 64;
   localparam int          USER_IW     = 6;
   localparam int          ID_BITS     = 8 * (REG_BYTES - USER_BYTES);
   localparam int          HDR_BYTES   = 4;
   localparam logic [7:0]  ERASED_BYTE = 8'hFF;
   localparam logic [7:0]  UNDEF_BYTE  = 8'hFF;
   localparam int          READY_BIT   = 7;
   localparam logic [2:0]  BIT_LAST    = 3'h7;

   //----------------------------------------------------------------------
   // Command bytes
   //----------------------------------------------------------------------
   localparam logic [7:0]  OP_PROGRAM  = 8'h9B;
   localparam logic [7:0]  OP_PAD      = 8'h00;
   localparam logic [7:0]  OP_READ     = 8'h77;

   //----------------------------------------------------------------------
   // Timing
   //----------------------------------------------------------------------
   localparam int          PAGE_PROGRAM_TIME_US = 6000;
   localparam int          CORE_CLK_PERIOD_NS   = 8;
   localparam int          PAGE_PROGRAM_CYCLES  =
      PAGE_PROGRAM_TIME_US * 1000 / CORE_CLK_PERIOD_NS;

   //----------------------------------------------------------------------
   // States and carriers
   //----------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE      = 3'b000,
      ST_PROG_HDR  = 3'b001,
      ST_PROG_DATA = 3'b010,
      ST_READ      = 3'b011,
      ST_SKIP      = 3'b100,
      ST_BUSY      = 3'b101
   } osr_state_e;

   typedef struct packed {
      logic [7:0] data;
      logic       tgl;
   } osr_xfer_s;

endpackage

//--- hw/osr_link.sv
// Serial shift engine on the controller's clock: bytes in, bytes out
`timescale 1ns/100ps
module osr_link
   import osr_pkg::*;
(
   input  wire logic      spi_clk_i,
   input  wire logic      sel_n_i,
   input  wire logic      rst_n_i,
   input  wire logic      mosi_i,
   input  wire osr_xfer_s tx_i,
   output osr_xfer_s      rx_o,
   output logic           miso_o
);

   logic [2:0] bit_cnt;
   logic [6:0] shift_in;
   logic [7:0] tx_shift;
   logic [7:0] rd_hold;
   logic [2:0] ack_q;

   wire        byte_done = (bit_cnt == BIT_LAST);
   wire        ack_ev    = ack_q[2] ^ ack_q[1];

   //----------------------------------------------------------------------
   // Receive side
   //----------------------------------------------------------------------
   // Frame state clears on select high, as the clock stops between frames
   always_ff @(posedge spi_clk_i or posedge sel_n_i) begin
      if (sel_n_i) begin
         bit_cnt  <= 3'h0;
         shift_in <= 7'h00;
      end else begin
         bit_cnt  <= bit_cnt + 3'h1;
         shift_in <= {shift_in[5:0], mosi_i};   // see RL6
      end
   end

   // Byte and toggle persist across frames so the core sees no false event
   always_ff @(posedge spi_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_o <= '0;
      end else if (byte_done) begin
         rx_o.data <= {shift_in, mosi_i};        // see RL8
         rx_o.tgl  <= ~rx_o.tgl;
      end
   end

   //----------------------------------------------------------------------
   // Transmit side
   //----------------------------------------------------------------------
   always_ff @(posedge spi_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_q   <= 3'h0;
         rd_hold <= UNDEF_BYTE;
      end else begin
         ack_q <= {ack_q[1:0], tx_i.tgl};
         if (ack_ev) begin
            rd_hold <= tx_i.data;
         end
      end
   end

   // Shift on the falling edge so the bit is steady at the rising sample
   always_ff @(negedge spi_clk_i or posedge sel_n_i) begin
      if (sel_n_i) begin
         tx_shift <= UNDEF_BYTE;
      end else if (bit_cnt == 3'h0) begin
         tx_shift <= rd_hold;                    // see RL16
      end else begin
         tx_shift <= {tx_shift[6:0], 1'b1};
      end
   end

   assign miso_o = tx_shift[7];

endmodule

//--- hw/osr_top.sv
// Security register block: command decode, OTP field, page buffer, timing
`timescale 1ns/100ps
//----------------------------------------------------------------------
// Overview of operation
// RL1: Register holds 128 bytes, user then identifier
// RL2: User field delivered erased, reads all ones
// RL3: User field programs once, never altered after
// RL4: Identifier bytes fixed, no command changes them
// RL5: Only user field programmable, no erase needed
// RL6: Controller selects with clock high, MSB first
// RL7: Program starts with 9B then three zeros
// RL8: Controller sends 64 data bytes in order
// RL9: Data beyond 64 bytes wraps to location 0
// RL10: Short program leaves unsupplied bytes unguaranteed
// RL11: Controller deselects on a falling clock edge
// RL12: Select rising ends program, starts timed cycle
// RL13: Ready bit 7 low while programming runs
// RL14: Program uses first page buffer as storage
// RL15: Read starts with 77 then three dummies
// RL16: Read returns bytes 0 to 127, MSB first
// RL17: Controller may end a read early
// RL18: Bytes after location 127 are undefined
// RL19: Program after locking leaves field unchanged
// RL20: Controller waits for ready before next command
//----------------------------------------------------------------------
module osr_top
   import osr_pkg::*;
#(
   parameter int                 PROG_CYCLES = PAGE_PROGRAM_CYCLES,
   // Identifier contents: arbitrary value
   parameter logic [ID_BITS-1:0] FACTORY_ID  = {32{16'hC3A5}}
) (
   input  wire logic       CORE_CLK_I,
   input  wire logic       RST_N_I,
   input  wire logic       SPI_CLK_I,
   input  wire logic       FLASH_SELECT_LOW_N_I,
   input  wire logic       MOSI_I,
   output logic            MISO_O,
   output logic [7:0]      STATUS_O,
   output logic            FIELD_LOCKED_O
);

   localparam int TW = $clog2(PROG_CYCLES + 1);

   if (PROG_CYCLES < 1) begin : g_bad_cycles
      $error("PROG_CYCLES must be at least one");
   end

   if ((1 << USER_IW) != USER_BYTES) begin : g_bad_index
      $error("USER_IW does not index the user field");
   end

   //----------------------------------------------------------------------
   // Declarations
   //----------------------------------------------------------------------
   osr_xfer_s   rx;
   osr_xfer_s   tx;
   osr_state_e  state;
   osr_state_e  next_state;
   logic [4:0]  sel_q;
   logic [2:0]  rx_q;
   logic [7:0]  cnt;
   logic [7:0]  rd_idx;
   logic [TW-1:0] timer;
   logic        locked;
   logic        ready;
   logic [7:0]  field    [USER_BYTES];
   logic [7:0]  page_buf [USER_BYTES];

   //----------------------------------------------------------------------
   // Link engine on the controller's clock
   //----------------------------------------------------------------------
   osr_link osr_link_inst (
      .spi_clk_i (SPI_CLK_I),
      .sel_n_i   (FLASH_SELECT_LOW_N_I),
      .rst_n_i   (RST_N_I),
      .mosi_i    (MOSI_I),
      .tx_i      (tx),
      .rx_o      (rx),
      .miso_o    (MISO_O)
   );

   //----------------------------------------------------------------------
   // Crossing into the core clock
   //----------------------------------------------------------------------
   // Two sync stages then two delay stages, so the last byte lands first
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         sel_q <= 5'h1F;
         rx_q  <= 3'h0;
      end else begin
         sel_q <= {sel_q[3:0], FLASH_SELECT_LOW_N_I};
         rx_q  <= {rx_q[1:0], rx.tgl};
      end
   end

   //----------------------------------------------------------------------
   // Decode
   //----------------------------------------------------------------------
   wire             idle       = sel_q[4];
   wire             frame_end  = sel_q[3] & ~sel_q[4];
   wire             byte_ev    = rx_q[2] ^ rx_q[1];
   wire             first_byte = byte_ev & (cnt == 8'h00);
   wire [7:0]       data_pos   = cnt - 8'(HDR_BYTES);
   wire [USER_IW-1:0] buf_idx  = data_pos[USER_IW-1:0];
   wire             buf_we     = (state == ST_PROG_DATA) & byte_ev;
   wire             prog_start = (state == ST_IDLE) & first_byte
                                 & (rx.data == OP_PROGRAM);
   wire             rd_start   = (state == ST_IDLE) & first_byte
                                 & (rx.data == OP_READ);
   wire             rd_step    = (state == ST_READ) & byte_ev
                                 & (cnt >= 8'(HDR_BYTES - 1));
   wire             rd_send    = rd_start | rd_step;
   wire             rd_end     = (rd_idx == 8'(REG_BYTES));
   wire [7:0]       next_rd_idx = rd_start ? 8'h00 :
                                  rd_end   ? rd_idx : rd_idx + 8'h01;
   wire [7:0]       id_pos     = next_rd_idx - 8'(USER_BYTES);
   wire [8:0]       id_bit     = {id_pos[USER_IW-1:0], 3'b000};
   wire [7:0]       rd_byte    =
      (next_rd_idx < 8'(USER_BYTES)) ? field[next_rd_idx[USER_IW-1:0]] :
      (next_rd_idx < 8'(REG_BYTES))  ? FACTORY_ID[id_bit +: 8] :
                                       UNDEF_BYTE;
   wire             busy_last  = (timer == TW'(PROG_CYCLES - 1));
   wire             commit     = (state == ST_BUSY) & busy_last & ~locked;

   //----------------------------------------------------------------------
   // Command state machine
   //----------------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (prog_start) begin
               next_state = ST_PROG_HDR;                // see RL7
            end else if (rd_start) begin
               next_state = ST_READ;                    // see RL15
            end else if (byte_ev) begin
               next_state = ST_SKIP;
            end
         end
         ST_PROG_HDR: begin
            if (frame_end) begin
               next_state = ST_IDLE;
            end else if (byte_ev && rx.data != OP_PAD) begin
               next_state = ST_SKIP;                    // see RL7
            end else if (byte_ev && cnt == 8'(HDR_BYTES - 1)) begin
               next_state = ST_PROG_DATA;
            end
         end
         ST_PROG_DATA: begin
            if (frame_end) begin
               next_state = ST_BUSY;                    // see RL12
            end
         end
         ST_READ, ST_SKIP: begin
            if (frame_end) begin
               next_state = ST_IDLE;                    // see RL17
            end
         end
         ST_BUSY: begin
            if (busy_last) begin
               next_state = ST_IDLE;                    // see RL20
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         state <= ST_IDLE;
         ready <= 1'b1;
      end else begin
         state <= next_state;
         ready <= (next_state != ST_BUSY);             // see RL13
      end
   end

   // Byte position within the current frame
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I || idle) begin
         cnt <= 8'h00;
      end else if (byte_ev) begin
         cnt <= cnt + 8'h01;
      end
   end

   // Self-timed programming cycle
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I || state != ST_BUSY) begin
         timer <= '0;
      end else begin
         timer <= timer + TW'(1);                      // see RL12
      end
   end

   //----------------------------------------------------------------------
   // Page buffer and one-time field
   //----------------------------------------------------------------------
   // Data wraps within the buffer; stale entries stay where nothing arrived
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         for (int i = 0; i < USER_BYTES; i++) begin
            page_buf[i] <= ERASED_BYTE;
         end
      end else if (buf_we) begin
         page_buf[buf_idx] <= rx.data;                 // see RL9 RL14 RL10
      end
   end

   // Reset models a part as delivered; only a first program lands
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         locked <= 1'b0;
         for (int i = 0; i < USER_BYTES; i++) begin
            field[i] <= ERASED_BYTE;                   // see RL2
         end
      end else if (commit) begin
         locked <= 1'b1;                               // see RL3 RL19
         for (int i = 0; i < USER_BYTES; i++) begin
            field[i] <= page_buf[i];                   // see RL5 RL10
         end
      end
   end

   //----------------------------------------------------------------------
   // Read data towards the link
   //----------------------------------------------------------------------
   // Next byte is fetched a whole byte ahead of its shift-out
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         rd_idx <= 8'h00;
         tx     <= '0;
      end else if (rd_send) begin
         rd_idx  <= next_rd_idx;                       // see RL16
         tx.data <= rd_byte;                           // see RL1 RL4 RL18
         tx.tgl  <= ~tx.tgl;
      end
   end

   assign STATUS_O       = 8'(ready) << READY_BIT;
   assign FIELD_LOCKED_O = locked;

   //----------------------------------------------------------------------
   // Checks
   //----------------------------------------------------------------------
   logic [USER_BYTES*8-1:0] field_flat;

   for (genvar g = 0; g < USER_BYTES; g++) begin : g_flat
      assign field_flat[8*g +: 8] = field[g];
   end

   default clocking cb @(posedge CORE_CLK_I);
   endclocking

   default disable iff (!RST_N_I);

   prog_start_a: assert property ( // see RL12
      state == ST_PROG_DATA && frame_end
      |=> state == ST_BUSY && !STATUS_O[READY_BIT]
   ) else $error("program cycle did not start at deselect");

   busy_hold_a: assert property ( // see RL13
      state == ST_BUSY && !busy_last
      |=> state == ST_BUSY && STATUS_O == 8'h00
   ) else $error("busy cycle ended early");

   busy_end_a: assert property ( // see RL13
      state == ST_BUSY && busy_last
      |=> state == ST_IDLE && STATUS_O[READY_BIT]
   ) else $error("ready not restored after program cycle");

   hdr_check_a: assert property ( // see RL7
      state == ST_PROG_HDR && byte_ev && !frame_end && rx.data != OP_PAD
      |=> state == ST_SKIP
   ) else $error("bad program header accepted");

   wrap_a: assert property ( // see RL9
      buf_we && cnt == 8'(HDR_BYTES + USER_BYTES)
      |=> page_buf[0] == $past(rx.data)
   ) else $error("data past the field did not wrap to zero");

   commit_a: assert property ( // see RL14
      commit
      |=> locked && field[0] == $past(page_buf[0])
          && field[USER_BYTES-1] == $past(page_buf[USER_BYTES-1])
   ) else $error("field not loaded from page buffer");

   otp_once_a: assert property ( // see RL3
      locked |=> locked && $stable(field_flat)
   ) else $error("locked field changed");

   erased_a: assert property ( // see RL2
      !locked |-> field_flat == {USER_BYTES{ERASED_BYTE}}
   ) else $error("unprogrammed field not erased");

   read_first_a: assert property ( // see RL16
      rd_start |=> tx.data == field[0] && tx.tgl != $past(tx.tgl)
   ) else $error("read did not start at location zero");

   read_id_a: assert property ( // see RL4
      rd_step && next_rd_idx == 8'(USER_BYTES)
      |=> tx.data == FACTORY_ID[7:0]
   ) else $error("identifier byte wrong");

   read_undef_a: assert property ( // see RL18
      rd_step && rd_idx >= 8'(REG_BYTES - 1)
      |=> tx.data == UNDEF_BYTE && rd_idx == 8'(REG_BYTES)
   ) else $error("data past the register not undefined filler");

   busy_ignore_a: assert property ( // see RL20
      state == ST_BUSY && byte_ev |=> !$changed(tx.tgl)
   ) else $error("command taken while busy");

   hdr_accept_a: assert property ( // see RL7
      state == ST_PROG_HDR && byte_ev && !frame_end
      && rx.data == OP_PAD && cnt == 8'(HDR_BYTES - 1)
      |=> state == ST_PROG_DATA
   ) else $error("valid program header refused");

   buf_write_a: assert property ( // see RL14
      buf_we |=> page_buf[$past(buf_idx)] == $past(rx.data)
   ) else $error("data byte not stored in page buffer");

   read_step_a: assert property ( // see RL16
      rd_step && rd_idx < 8'(REG_BYTES)
      |=> rd_idx == $past(rd_idx) + 8'h01 && tx.tgl != $past(tx.tgl)
   ) else $error("read position did not advance");

   id_last_a: assert property ( // see RL4
      rd_step && next_rd_idx == 8'(REG_BYTES - 1)
      |=> tx.data == FACTORY_ID[ID_BITS-1 -: 8]
   ) else $error("last identifier byte wrong");

   skip_hold_a: assert property ( // see RL7
      state == ST_SKIP && !frame_end |=> state == ST_SKIP
   ) else $error("ignored frame left the skip state");

   busy_timer_a: assert property ( // see RL12
      state == ST_BUSY |-> timer < TW'(PROG_CYCLES)
   ) else $error("program timer overran");

   ready_idle_a: assert property ( // see RL13
      state != ST_BUSY |-> STATUS_O == 8'(1 << READY_BIT)
   ) else $error("ready bit low outside a program cycle");

endmodule

//--- test/osr_ctrl_model.sv
// Controller model: drives the serial port the way the user logic does
`timescale 1ns/100ps
module osr_ctrl_model
   import osr_pkg::*;
(
   output logic      sclk_o,
   output logic      sel_n_o,
   output logic      mosi_o,
   input  wire logic miso_i
);
   //----------------------------------------------------------------------
   // Frame tasks, clock stands high between frames
   //----------------------------------------------------------------------
   // A deselect edge at start clears the link's frame state
   initial begin
      sclk_o  = 1'b1;
      sel_n_o = 1'b0;
      mosi_o  = 1'b0;
      #1 sel_n_o = 1'b1;
   end

   task automatic start_frame();
      #5 sel_n_o = 1'b0;
      #3;
   endtask

   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int b = 7; b >= 0; b--) begin
         sclk_o = 1'b0;
         mosi_o = tx[b];
         #6 sclk_o = 1'b1;
         rx[b] = miso_i;
         #6;
      end
   endtask

   // Deselect only after a falling edge; stopping at any byte ends a read early
   task automatic end_frame();
      sclk_o = 1'b0;
      #3 sel_n_o = 1'b1;
      mosi_o = ~mosi_o;
      #3 sclk_o = 1'b1;
   endtask
endmodule

//--- test/tb_top.sv
// Testbench for the security register block
`timescale 1ns/100ps
module tb_top;
   import osr_pkg::*;
   localparam int                 P   = 20;
   localparam logic [ID_BITS-1:0] FID = {8{64'h0123456789ABCDEF}};
   logic       core_clk    = 1'b0;
   logic       rst_n       = 1'b1;
   wire        sclk;
   wire        sel_n;
   wire        mosi;
   wire        miso;
   wire  [7:0] status;
   wire        locked;
   int         n_mismatch  = 0;
   int         check_count = 0;
   int         cyc         = 0;
   logic [7:0] mem [REG_BYTES];

   always #4 core_clk = ~core_clk;

   osr_top #(.PROG_CYCLES(P), .FACTORY_ID(FID)) osr_top_inst (
      .CORE_CLK_I           (core_clk),
      .RST_N_I              (rst_n),
      .SPI_CLK_I            (sclk),
      .FLASH_SELECT_LOW_N_I (sel_n),
      .MOSI_I               (mosi),
      .MISO_O               (miso),
      .STATUS_O             (status),
      .FIELD_LOCKED_O       (locked)
   );

   osr_ctrl_model osr_ctrl_model_inst (
      .sclk_o  (sclk),
      .sel_n_o (sel_n),
      .mosi_o  (mosi),
      .miso_i  (miso)
   );

   //----------------------------------------------------------------------
   // Shared tasks
   //----------------------------------------------------------------------
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_mismatch++;
         summarize();
      end
   end

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic read_reg(input int n);
      logic [7:0] rx;
      osr_ctrl_model_inst.start_frame();
      osr_ctrl_model_inst.xfer(OP_READ, rx);
      for (int i = 0; i < 3; i++) begin
         osr_ctrl_model_inst.xfer(8'hA5, rx);
      end
      for (int i = 0; i < n; i++) begin
         osr_ctrl_model_inst.xfer(8'h00, rx);
         check($sformatf("read byte %0d", i), rx, mem[i]);
      end
      osr_ctrl_model_inst.end_frame();
      #60;
   endtask

   task automatic send_prog(input logic [7:0] op, input logic [7:0] pad, input int n,
                            input logic [7:0] base);
      logic [7:0] rx;
      osr_ctrl_model_inst.start_frame();
      osr_ctrl_model_inst.xfer(op, rx);
      for (int i = 0; i < 3; i++) begin
         osr_ctrl_model_inst.xfer(pad, rx);
      end
      for (int j = 0; j < n; j++) begin
         osr_ctrl_model_inst.xfer(base ^ 8'(j * 5), rx);
      end
      osr_ctrl_model_inst.end_frame();
   endtask

   // Waits out the busy period before the next command
   task automatic check_cycle();
      int w   = 0;
      int cnt = 0;
      while (status !== 8'h00 && w < 20) begin
         @(negedge core_clk);
         w++;
      end
      check("busy start", status, 8'h00);
      while (status === 8'h00 && cnt < 1000) begin
         @(negedge core_clk);
         cnt++;
      end
      check("busy length", 8'(cnt), 8'(P));
      check("ready", status, 8'h80);
      check("locked", {7'h00, locked}, 8'h01);
   endtask

   //----------------------------------------------------------------------
   // Scenarios
   //----------------------------------------------------------------------
   task automatic s_reset_state();
      @(negedge core_clk);
      check("status", status, 8'h80);
      check("locked", {7'h00, locked}, 8'h00);
      check("miso idle", {7'h00, miso}, 8'h01);
      for (int i = 0; i < REG_BYTES; i++) begin
         mem[i] = (i < USER_BYTES) ? 8'hFF : FID[8 * (i - USER_BYTES) +: 8];
      end
      read_reg(REG_BYTES);
   endtask

   task automatic s_refused_frames();
      send_prog(8'h5A, OP_PAD, 64, 8'h11);
      #60;
      send_prog(OP_PROGRAM, 8'h01, 64, 8'h22);
      #60;
      @(negedge core_clk);
      check("status after bad", status, 8'h80);
      check("locked after bad", {7'h00, locked}, 8'h00);
      read_reg(4);
   endtask

   task automatic s_program_wrap();
      send_prog(OP_PROGRAM, OP_PAD, 66, 8'h3C);
      for (int j = 0; j < 66; j++) begin
         mem[j % USER_BYTES] = 8'h3C ^ 8'(j * 5);
      end
      check_cycle();
      read_reg(REG_BYTES);
   endtask

   task automatic s_program_again();
      send_prog(OP_PROGRAM, OP_PAD, 64, 8'hC3);
      check_cycle();
      read_reg(REG_BYTES);
   endtask

   initial begin
      rst_n <= 1'b0;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge core_clk);
      s_reset_state();
      s_refused_frames();
      s_program_wrap();
      s_program_again();
      summarize();
   end
endmodule
